// [design/io_assign_pkg.sv]
// Constants, field layout and mode encodings for the I/O function assignment block.
// Assumes a single 40 MHz system clock and a classic Wishbone register bus.
//
// What this block does
// R01 - Counter channels 0, 2, 4 and 6 can be off, up, down, two-phase, split up/down or direction-controlled.
// R02 - Counter channels 1, 3, 5 and 7 can only be off, up or down on their own input, and all start off.
// R03 - Inputs 4 to 7 can each be a normal input or the home input of pulse channel 0 to 3, normal by default.
// R04 - Input 6 can be the reset input of counter 0 and input 7 the reset input of counter 2.
// R05 - Each output pair is normal, pulse train on both pins, or PWM on the first pin, normal by default.
// R06 - Each of inputs 0 to 7 has its own pulse-catch enable, all off by default.
// R07 - Each of inputs 0 to 7 has its own interrupt enable, all off by default.
// R08 - An input interrupts on its rising edge unless its edge bit asks for the falling edge.
// R09 - An input claimed by a counter loses pulse catch and interrupt, and pulse catch beats interrupt.
// R10 - A two-input mode on an even counter makes the next odd channel's setting ignored.
// R11 - An output given to pulse train or PWM is not driven from the normal output path.
// R12 - Software that uses home return sets the home input and does not also make it a counter input.
package io_assign_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int unsigned ADR_W    = 12;
    localparam int unsigned IDX_W    = 10;
    localparam int unsigned NUM_CFG  = 6;
    localparam logic [IDX_W-1:0] IDX_CNT_LOW    = 10'h190;
    localparam logic [IDX_W-1:0] IDX_CNT_HIGH   = 10'h191;
    localparam logic [IDX_W-1:0] IDX_OUT_SEL    = 10'h192;
    localparam logic [IDX_W-1:0] IDX_CATCH_EN   = 10'h193;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN     = 10'h194;
    localparam logic [IDX_W-1:0] IDX_IRQ_EDGE   = 10'h195;
    localparam logic [IDX_W-1:0] IDX_PIN_STATE  = 10'h196;
    localparam logic [IDX_W-1:0] IDX_CATCH_STAT = 10'h197;
    localparam logic [2:0]       SLOT_NONE      = 3'h7;
    localparam logic [15:0]      CFG_RESET      = 16'h0000;
    // Writable bits per configuration word, slot 5 first
    localparam logic [NUM_CFG-1:0][15:0] CFG_WMASK =
        {16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff, 16'h03ff};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned EVEN_A_LSB = 0;
    localparam int unsigned ODD_A_LSB  = 3;
    localparam int unsigned EVEN_B_LSB = 5;
    localparam int unsigned ODD_B_LSB  = 8;
    localparam int unsigned HOME4_BIT  = 10;
    localparam int unsigned HOME5_BIT  = 11;
    localparam int unsigned FN6_LSB    = 12;
    localparam int unsigned FN7_LSB    = 14;
    localparam int unsigned OUT_SEL_W  = 2;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [2:0] {
        CNT_OFF        = 3'h0,
        CNT_INC        = 3'h1,
        CNT_DEC        = 3'h2,
        CNT_TWO_PHASE  = 3'h3,
        CNT_INDIV      = 3'h4,
        CNT_DIR_CTL    = 3'h5
    } cnt_mode_e;

    typedef enum logic [1:0] {
        OUT_NORMAL = 2'h0,
        OUT_PULSE  = 2'h1,
        OUT_PWM    = 2'h2
    } out_mode_e;

    typedef enum logic [1:0] {
        IN_FN_NORMAL = 2'h0,
        IN_FN_HOME   = 2'h1,
        IN_FN_RESET  = 2'h2
    } in_fn_e;

endpackage : io_assign_pkg

// [design/fast_counter_decode.sv]
// One counter channel front end: turns its input pair into count pulses.
// Assumes inputs already synchronous to the clock and a mode vetted by the parent.
`timescale 1ns/1ps
module fast_counter_decode (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire io_assign_pkg::cnt_mode_e mode,
    input  wire logic                   in_a,
    input  wire logic                   in_b,
    output logic                        up,
    output logic                        down
);
    typedef struct packed {
        logic a;
        logic b;
        logic up;
        logic dn;
    } dec_s;

    dec_s q;
    dec_s d;
    logic rise_a;
    logic rise_b;

    always_comb begin
        rise_a = in_a & ~q.a;
        rise_b = in_b & ~q.b;
        d      = q;
        d.a    = in_a;
        d.b    = in_b;
        d.up   = 1'b0;
        d.dn   = 1'b0;
        // R01 counting modes, single- and two-input
        case (mode)
            io_assign_pkg::CNT_INC: begin
                d.up = rise_a;
            end
            io_assign_pkg::CNT_DEC: begin
                d.dn = rise_a;
            end
            io_assign_pkg::CNT_TWO_PHASE: begin
                // Single-edge quadrature: phase of b on a's rise gives direction
                d.up = rise_a & ~in_b;
                d.dn = rise_a & in_b;
            end
            io_assign_pkg::CNT_INDIV: begin
                // Coincident edges cancel
                d.up = rise_a & ~rise_b;
                d.dn = rise_b & ~rise_a;
            end
            io_assign_pkg::CNT_DIR_CTL: begin
                d.up = rise_a & ~in_b;
                d.dn = rise_a & in_b;
            end
            default: begin
                d.up = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign up   = q.up;
    assign down = q.dn;

endmodule : fast_counter_decode

// [design/input_event_unit.sv]
// Pulse catch and edge interrupt for one controller input, with priority.
// Assumes the input is synchronous and catch_clr comes from a status read.
`timescale 1ns/1ps
module input_event_unit (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level,
    input  wire logic counter_use,
    input  wire logic catch_en,
    input  wire logic irq_en,
    input  wire logic fall_edge,
    input  wire logic catch_clr,
    output logic      catch_flag,
    output logic      irq
);
    typedef struct packed {
        logic lvl;
        logic catch_f;
        logic irq;
    } evt_s;

    evt_s q;
    evt_s d;
    logic rise;
    logic fall;
    logic catch_act;
    logic irq_act;

    always_comb begin
        rise      = level & ~q.lvl;
        fall      = ~level & q.lvl;
        // R09 counter, then catch, then interrupt
        catch_act = catch_en & ~counter_use;
        irq_act   = irq_en & ~counter_use & ~catch_act;
        d         = q;
        d.lvl     = level;
        // R06 set beats clear
        d.catch_f = (catch_act & rise) | (q.catch_f & ~catch_clr);
        // R08 edge choice
        d.irq     = irq_act & (fall_edge ? fall : rise);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign catch_flag = q.catch_f;
    assign irq        = q.irq;

    property p_irq_falling;
        @(posedge clk) disable iff (!rst_n)
        (irq_act && fall_edge && fall) |=> irq;
    endproperty
    a_irq_falling: assert property (p_irq_falling) else $error("falling-edge irq missed"); // R08

    property p_irq_cause;
        @(posedge clk) disable iff (!rst_n)
        irq |-> $past(irq_en && !counter_use && !(catch_en && !counter_use));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without right to it"); // R09

    property p_catch_hold;
        @(posedge clk) disable iff (!rst_n)
        (catch_act && rise) |=> catch_flag ##1 (catch_flag || $past(catch_clr));
    endproperty
    a_catch_hold: assert property (p_catch_hold) else $error("caught pulse lost"); // R06

endmodule : input_event_unit

// [design/controller_io_function_assign.sv]
// Top of the I/O function assignment block: config words, input routing, output mux.
// Assumes a classic Wishbone master on SYS_CLK and field devices on the terminals.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module controller_io_function_assign (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [11:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [7:0]  IN_TERM,
    input  wire logic [7:0]  NORMAL_OUT,
    input  wire logic [3:0]  PULSE_OUT_A,
    input  wire logic [3:0]  PULSE_OUT_B,
    input  wire logic [3:0]  PWM_OUT,
    output logic      [7:0]  OUT_TERM,
    output logic      [7:0]  COUNT_UP,
    output logic      [7:0]  COUNT_DOWN,
    output logic      [1:0]  COUNT_RESET,
    output logic      [3:0]  HOME_IN,
    output logic      [7:0]  CATCH_FLAG,
    output logic      [7:0]  IRQ_PULSE
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic                                        ack;
        logic [31:0]                                 dat;
        logic [io_assign_pkg::NUM_CFG-1:0][15:0]     cfg;
        logic [7:0]                                  out;
        logic [3:0]                                  home;
        logic [1:0]                                  rst;
    } top_s;

    top_s q;
    top_s d;

    logic [7:0][2:0]                  ch_mode;
    io_assign_pkg::cnt_mode_e [7:0]   ch_mode_e;
    logic [7:0]                       in_used;
    logic [3:0][1:0]                  out_mode;
    logic [7:0]                       catch_clr;
    logic [2:0]                       even_v;
    logic [1:0]                       odd_v;
    logic                             two_in;
    logic                             req;
    logic                             wr;
    logic                             rd_catch;
    logic [2:0]                       slot;
    logic [io_assign_pkg::IDX_W-1:0]  idx;
    logic [15:0]                      lanes;
    logic [1:0]                       fn6;
    logic [1:0]                       fn7;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [2:0] cfg_slot(input logic [io_assign_pkg::IDX_W-1:0] a);
        logic [2:0] s;
        s = io_assign_pkg::SLOT_NONE;
        if (a == io_assign_pkg::IDX_CNT_LOW) begin
            s = 3'h0;
        end else if (a == io_assign_pkg::IDX_CNT_HIGH) begin
            s = 3'h1;
        end else if (a == io_assign_pkg::IDX_OUT_SEL) begin
            s = 3'h2;
        end else if (a == io_assign_pkg::IDX_CATCH_EN) begin
            s = 3'h3;
        end else if (a == io_assign_pkg::IDX_IRQ_EN) begin
            s = 3'h4;
        end else if (a == io_assign_pkg::IDX_IRQ_EDGE) begin
            s = 3'h5;
        end
        return s;
    endfunction : cfg_slot

    // Unknown codes fall back to off so a bad write cannot start counting
    function automatic logic [2:0] even_mode(input logic [2:0] v);
        logic [2:0] m;
        m = (v > io_assign_pkg::CNT_DIR_CTL) ? io_assign_pkg::CNT_OFF : v;
        return m;
    endfunction : even_mode

    function automatic logic [2:0] odd_mode(input logic [1:0] v);
        logic [2:0] m;
        m = io_assign_pkg::CNT_OFF;
        if (v == io_assign_pkg::CNT_INC[1:0]) begin
            m = io_assign_pkg::CNT_INC;
        end else if (v == io_assign_pkg::CNT_DEC[1:0]) begin
            m = io_assign_pkg::CNT_DEC;
        end
        return m;
    endfunction : odd_mode

    function automatic logic is_two_input(input logic [2:0] m);
        return (m == io_assign_pkg::CNT_TWO_PHASE) || (m == io_assign_pkg::CNT_INDIV)
            || (m == io_assign_pkg::CNT_DIR_CTL);
    endfunction : is_two_input

    // ****************************************
    // Input routing
    // ****************************************
    always_comb begin
        ch_mode = '0;
        in_used = '0;
        even_v  = '0;
        odd_v   = '0;
        two_in  = 1'b0;
        fn6     = q.cfg[1][io_assign_pkg::FN6_LSB +: 2];
        fn7     = q.cfg[1][io_assign_pkg::FN7_LSB +: 2];
        for (int k = 0; k < 4; k++) begin
            if (k % 2 == 1) begin
                even_v = q.cfg[k/2][io_assign_pkg::EVEN_B_LSB +: 3];
                odd_v  = q.cfg[k/2][io_assign_pkg::ODD_B_LSB +: 2];
            end else begin
                even_v = q.cfg[k/2][io_assign_pkg::EVEN_A_LSB +: 3];
                odd_v  = q.cfg[k/2][io_assign_pkg::ODD_A_LSB +: 2];
            end
            // R01 even channel modes
            ch_mode[2*k] = even_mode(even_v);
            two_in       = is_two_input(ch_mode[2*k]);
            // R10 odd setting ignored
            // R02 odd channel limited
            ch_mode[2*k+1] = two_in ? io_assign_pkg::CNT_OFF : odd_mode(odd_v);
            in_used[2*k]   = ch_mode[2*k] != io_assign_pkg::CNT_OFF;
            in_used[2*k+1] = two_in || (ch_mode[2*k+1] != io_assign_pkg::CNT_OFF);
        end
        // R04 reset inputs are counter inputs too
        if (fn6 == io_assign_pkg::IN_FN_RESET) begin
            in_used[6] = 1'b1;
        end
        if (fn7 == io_assign_pkg::IN_FN_RESET) begin
            in_used[7] = 1'b1;
        end
    end

    generate
        for (genvar c = 0; c < 8; c++) begin : g_cnt
            assign ch_mode_e[c] = io_assign_pkg::cnt_mode_e'(ch_mode[c]);
            fast_counter_decode u_dec (
                .clk   (SYS_CLK),
                .rst_n (RST_N),
                .mode  (ch_mode_e[c]),
                .in_a  (IN_TERM[c]),
                .in_b  ((c % 2 == 0) ? IN_TERM[c | 1] : 1'b0),
                .up    (COUNT_UP[c]),
                .down  (COUNT_DOWN[c])
            );
            // R07 per-input enable
            input_event_unit u_evt (
                .clk         (SYS_CLK),
                .rst_n       (RST_N),
                .level       (IN_TERM[c]),
                .counter_use (in_used[c]),
                .catch_en    (q.cfg[3][c]),
                .irq_en      (q.cfg[4][c]),
                .fall_edge   (q.cfg[5][c]),
                .catch_clr   (catch_clr[c]),
                .catch_flag  (CATCH_FLAG[c]),
                .irq         (IRQ_PULSE[c])
            );
        end
    endgenerate

    // ****************************************
    // Bus slave and pin logic
    // ****************************************
    always_comb begin
        idx      = WB_ADR_I[io_assign_pkg::ADR_W-1:2];
        slot     = cfg_slot(idx);
        req      = WB_CYC_I & WB_STB_I & ~q.ack;
        wr       = req & WB_WE_I;
        rd_catch = req & ~WB_WE_I & (idx == io_assign_pkg::IDX_CATCH_STAT);
        // Only flags seen by this read are cleared; a fresh catch survives
        catch_clr = rd_catch ? CATCH_FLAG : 8'h00;
        lanes    = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        d        = q;
        d.ack    = req;
        d.dat    = 32'h0000_0000;
        if (wr && slot != io_assign_pkg::SLOT_NONE) begin
            d.cfg[slot] = ((q.cfg[slot] & ~lanes) | (WB_DAT_I[15:0] & lanes))
                        & io_assign_pkg::CFG_WMASK[slot];
        end
        if (req && !WB_WE_I) begin
            if (slot != io_assign_pkg::SLOT_NONE) begin
                d.dat = {16'h0000, q.cfg[slot]};
            end else if (idx == io_assign_pkg::IDX_PIN_STATE) begin
                d.dat = {24'h00_0000, IN_TERM};
            end else if (idx == io_assign_pkg::IDX_CATCH_STAT) begin
                d.dat = {24'h00_0000, CATCH_FLAG};
            end
        end
        // R03 home inputs
        d.home[0] = q.cfg[1][io_assign_pkg::HOME4_BIT] & IN_TERM[4];
        d.home[1] = q.cfg[1][io_assign_pkg::HOME5_BIT] & IN_TERM[5];
        d.home[2] = (fn6 == io_assign_pkg::IN_FN_HOME) & IN_TERM[6];
        d.home[3] = (fn7 == io_assign_pkg::IN_FN_HOME) & IN_TERM[7];
        // R04 counter reset inputs
        d.rst[0] = (fn6 == io_assign_pkg::IN_FN_RESET) & IN_TERM[6];
        d.rst[1] = (fn7 == io_assign_pkg::IN_FN_RESET) & IN_TERM[7];
        for (int k = 0; k < 4; k++) begin
            out_mode[k] = q.cfg[2][k*io_assign_pkg::OUT_SEL_W +: io_assign_pkg::OUT_SEL_W];
            // R05 output pair select
            // R11 normal path blocked
            case (out_mode[k])
                io_assign_pkg::OUT_PULSE: begin
                    d.out[2*k]   = PULSE_OUT_A[k];
                    d.out[2*k+1] = PULSE_OUT_B[k];
                end
                io_assign_pkg::OUT_PWM: begin
                    d.out[2*k]   = PWM_OUT[k];
                    d.out[2*k+1] = NORMAL_OUT[2*k+1];
                end
                default: begin
                    d.out[2*k]   = NORMAL_OUT[2*k];
                    d.out[2*k+1] = NORMAL_OUT[2*k+1];
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign WB_ACK_O    = q.ack;
    assign WB_DAT_O    = q.dat;
    assign OUT_TERM    = q.out;
    assign HOME_IN     = q.home;
    assign COUNT_RESET = q.rst;

    // ****************************************
    // Checks
    // ****************************************
    property p_ack_once;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle");

    property p_two_phase_up;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (ch_mode[0] == io_assign_pkg::CNT_TWO_PHASE && $rose(IN_TERM[0]) && !IN_TERM[1])
            |=> COUNT_UP[0] && !COUNT_DOWN[0];
    endproperty
    a_two_phase_up: assert property (p_two_phase_up) else $error("two-phase count missed"); // R01

    property p_odd_off_quiet;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (COUNT_UP[1] || COUNT_DOWN[1]) |-> $past(ch_mode[1]) != io_assign_pkg::CNT_OFF;
    endproperty
    a_odd_off_quiet: assert property (p_odd_off_quiet) else $error("odd channel counted while off"); // R02

    property p_home_route;
        @(posedge SYS_CLK) disable iff (!RST_N)
        HOME_IN[3] |-> $past(IN_TERM[7]) && ($past(fn7) == io_assign_pkg::IN_FN_HOME);
    endproperty
    a_home_route: assert property (p_home_route) else $error("home input misrouted"); // R03

    property p_reset_route;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ($past(fn6) == io_assign_pkg::IN_FN_RESET) |-> COUNT_RESET[0] == $past(IN_TERM[6]);
    endproperty
    a_reset_route: assert property (p_reset_route) else $error("counter reset misrouted"); // R04

    property p_pwm_pair;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (out_mode[1] == io_assign_pkg::OUT_PWM) |=>
            OUT_TERM[2] == $past(PWM_OUT[1]) && OUT_TERM[3] == $past(NORMAL_OUT[3]);
    endproperty
    a_pwm_pair: assert property (p_pwm_pair) else $error("PWM pair wrong"); // R05

    property p_pulse_blocks_normal;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (out_mode[0] == io_assign_pkg::OUT_PULSE) |=>
            OUT_TERM[1:0] == {$past(PULSE_OUT_B[0]), $past(PULSE_OUT_A[0])};
    endproperty
    a_pulse_blocks_normal: assert property (p_pulse_blocks_normal) else $error("normal leak"); // R11

    property p_odd_ignored;
        @(posedge SYS_CLK) disable iff (!RST_N)
        is_two_input(ch_mode[0]) |=> !COUNT_UP[1] && !COUNT_DOWN[1];
    endproperty
    a_odd_ignored: assert property (p_odd_ignored) else $error("odd setting not ignored"); // R10

    property p_counter_blocks_irq;
        @(posedge SYS_CLK) disable iff (!RST_N)
        in_used[0] [*2] |-> !IRQ_PULSE[0] && !$rose(CATCH_FLAG[0]);
    endproperty
    a_counter_blocks_irq: assert property (p_counter_blocks_irq) else $error("counter lost"); // R09

    property p_irq_rise_default;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (q.cfg[4][2] && !q.cfg[5][2] && !q.cfg[3][2] && !in_used[2] && $rose(IN_TERM[2]))
            |=> IRQ_PULSE[2] ##1 !IRQ_PULSE[2];
    endproperty
    a_irq_rise_default: assert property (p_irq_rise_default) else $error("rising irq wrong"); // R08

    c_pwm_used: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        out_mode[2] == io_assign_pkg::OUT_PWM ##1 OUT_TERM[4]);
    c_quad_down: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        ch_mode[0] == io_assign_pkg::CNT_TWO_PHASE ##1 COUNT_DOWN[0]);
    c_catch_read: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_catch && CATCH_FLAG != 8'h00);

endmodule : controller_io_function_assign

// [test/field_sensors.sv]
// Field sensor model: drives the input terminals of the I/O block.
// Assumes the bench asks for new levels between clock edges.
`timescale 1ns/1ps
module field_sensors (
    input  wire logic       clk,
    input  wire logic [7:0] want,
    output logic      [7:0] levels
);
    logic [7:0] lv_q = 8'h00;

    // Levels move only at an edge, as after the terminal synchronisers
    always @(posedge clk) begin
        lv_q <= want;
    end
    assign levels = lv_q;
endmodule : field_sensors

// [test/controller_io_function_assign_tb.sv]
// Self-checking bench for the I/O function assignment block.
// Assumes a Wishbone master here and the field sensor model on the inputs.
`timescale 1ns/1ps
module controller_io_function_assign_tb;
    logic        clk = 1'b0;
    logic        rst_n, cyc, stb, we, ack;
    logic [11:0] adr;
    logic [3:0]  sel, pa, pb, pwm, home;
    logic [31:0] dat, dat_o;
    logic [7:0]  want, terms, nout, oterm, cup, cdn, cflag, irq;
    logic [1:0]  crst;
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    field_sensors u_field (.clk(clk), .want(want), .levels(terms));

    controller_io_function_assign u_dut (
        .SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .IN_TERM(terms), .NORMAL_OUT(nout), .PULSE_OUT_A(pa), .PULSE_OUT_B(pb),
        .PWM_OUT(pwm), .OUT_TERM(oterm), .COUNT_UP(cup), .COUNT_DOWN(cdn),
        .COUNT_RESET(crst), .HOME_IN(home), .CATCH_FLAG(cflag), .IRQ_PULSE(irq));

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // A hung handshake ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic wb(input logic w, input logic [9:0] idx, input logic [15:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input string n, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 16'h0000, q);
        check(n, q, exp);
    endtask : rd

    // New level reaches the block one edge later; results settle after the next
    task automatic apply(input logic [7:0] v);
        @(posedge clk);
        want <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask : apply

    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            rd("cfg_reset", io_assign_pkg::IDX_CNT_LOW + 10'(i), 32'h0);
        end
        wr(10'h3ff, 16'hffff);
        rd("unmapped", 10'h3ff, 32'h0);
        wr(io_assign_pkg::IDX_CNT_LOW, 16'hffff);
        rd("cnt_low_mask", io_assign_pkg::IDX_CNT_LOW, {16'h0, io_assign_pkg::CFG_WMASK[0]});
    endtask : t_regs

    task automatic t_count();
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h0011);
        apply(8'h03);
        check("up_inc", {24'h0, cup}, 32'h01);
        check("down_odd", {24'h0, cdn}, 32'h02);
        apply(8'h00);
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h000b);
        apply(8'h01);
        check("up_two_phase", {24'h0, cup}, 32'h01);
        apply(8'h03);
        check("odd_ignored", {24'h0, cup}, 32'h00);
        apply(8'h02);
        apply(8'h03);
        check("down_two_phase", {24'h0, cdn}, 32'h01);
        apply(8'h00);
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h0004);
        apply(8'h02);
        check("down_indiv", {24'h0, cdn}, 32'h01);
        apply(8'h00);
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h0005);
        apply(8'h02);
        apply(8'h03);
        check("down_dir_ctl", {24'h0, cdn}, 32'h01);
        apply(8'h00);
    endtask : t_count

    task automatic t_home();
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h0000);
        // Home and reset inputs are kept clear of counter use
        wr(io_assign_pkg::IDX_CNT_HIGH, 16'h6400);
        apply(8'hd0);
        @(posedge clk);
        #1;
        check("home_in", {28'h0, home}, 32'h9);
        check("count_reset", {30'h0, crst}, 32'h1);
        rd("pin_state", io_assign_pkg::IDX_PIN_STATE, 32'hd0);
        apply(8'h00);
    endtask : t_home

    task automatic t_out();
        wr(io_assign_pkg::IDX_OUT_SEL, 16'h0009);
        @(posedge clk);
        nout <= 8'hff;
        pa   <= 4'hf;
        repeat (2) @(posedge clk);
        #1;
        check("out_mux", {24'h0, oterm}, 32'hf9);
    endtask : t_out

    task automatic t_events();
        wr(io_assign_pkg::IDX_CNT_LOW, 16'h0001);
        wr(io_assign_pkg::IDX_CNT_HIGH, 16'h0000);
        wr(io_assign_pkg::IDX_CATCH_EN, 16'h0003);
        wr(io_assign_pkg::IDX_IRQ_EN, 16'h000f);
        wr(io_assign_pkg::IDX_IRQ_EDGE, 16'h0008);
        apply(8'h0f);
        check("irq_rise", {24'h0, irq}, 32'h04);
        check("catch", {24'h0, cflag}, 32'h02);
        apply(8'h00);
        check("irq_fall", {24'h0, irq}, 32'h08);
        rd("catch_stat", io_assign_pkg::IDX_CATCH_STAT, 32'h02);
        @(posedge clk);
        #1;
        check("catch_clear", {24'h0, cflag}, 32'h00);
    endtask : t_events

    initial begin
        {rst_n, cyc, stb, we, adr, sel, dat} = '0;
        sel  = 4'h3;
        want = 8'h00;
        nout = 8'h00;
        {pa, pb, pwm} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_count();
        t_home();
        t_out();
        t_events();
        tally_and_finish();
    end
endmodule : controller_io_function_assign_tb
